/* rtl/twm_master.sv */
// Two-wire bus master: frames start, address, data, acknowledge and stop.
// Assumes open-drain pads and pull-ups outside; bus clock made here by a divider.
//
// How it works
// [R1] Data line changes only while clock line low, except start and stop.
// [R2] Start and stop are data-line edges while clock line is high.
// [R3] Bus counted busy from any start to stop; no start while busy.
// [R4] Repeated start keeps the bus; busy until the next stop.
// [R5] We as master open and close transfers and drive the clock.
// [R6] Address packet: seven address bits, direction bit, acknowledge bit.
// [R7] Direction one reads from the slave, zero writes to it.
// [R8] Addressed slave pulls data low in the ninth clock to acknowledge.
// [R9] Slave leaving data high refuses; we may stop or repeat start.
// [R10] Address byte goes out most significant bit first.
// [R11] All-zero address with write is general call; data follows normally.
// [R12] General call with read direction is refused by this master.
// [R13] Addresses with upper four bits all ones are refused.
// [R14] Data packet: eight bits MSB first, then one acknowledge bit.
// [R15] Master makes clock; receiving side drives the acknowledge bit.
// [R16] Acknowledge is low in ninth clock; high means not-acknowledge.
// [R17] Receiver answers not-acknowledge after its last wanted byte.
// [R18] Device unit stays off while its power-off bit is one.
// [R19] Bus clock runs at most at the fast-mode rate.
// [R20] Start is never followed straight by stop without an address.
// [R21] Slave may hold clock low; high phase timed after line rises.
// [R22] Lines are only pulled low or released, never driven high.
`include "twm_cfg.svh"

module twm_master (
	input wire logic mclk_i, // System clock, 100 MHz
	input wire logic rst_b_i, // Synchronous reset, active low
	input wire logic enable_i, // Keep the bus unit powered and running
	input wire logic cmd_valid_i, // Command offered
	output logic cmd_ready_o, // Command may be taken
	input wire logic [1:0] cmd_kind_i, // Start, write, read or stop
	input wire logic [6:0] cmd_addr_i, // Slave address for start
	input wire logic cmd_dir_i, // Direction bit for start
	input wire logic [7:0] cmd_data_i, // Byte for write
	input wire logic cmd_nack_i, // Answer not-acknowledge on read
	output logic rsp_valid_o, // One-cycle answer
	output logic [7:0] rsp_data_o, // Byte read
	output logic rsp_nack_o, // Ninth bit was high
	output logic rsp_err_o, // Command refused
	output logic bus_busy_o, // Bus occupied
	output logic serial_bus_power_off_bit_o, // Wanted device power-off bit
	input wire logic scl_i, // Clock line level
	output logic scl_o, // Clock line drive value
	output logic scl_oe_o, // Clock line pulled low
	input wire logic sda_i, // Data line level
	output logic sda_o, // Data line drive value
	output logic sda_oe_o // Data line pulled low
);
	twm_pkg::twm_state_t state_r, state_nxt;
	logic [1:0] line_s;
	logic scl_s, sda_s, sda_d_r;
	logic [7:0] cnt_r;
	logic [3:0] bit_cnt_r;
	logic [8:0] shift_r, rx_r;
	logic en_r, busy_r, acc, start_ok, bad_cmd, qtr_done, half_done;
	logic ready_r, rsp_valid_r, rsp_nack_r, rsp_err_r, scl_oe_r, sda_oe_r, pwr_off_r;
	logic [7:0] rsp_data_r;

	// Clock line pulled low in this state
	function automatic logic scl_pull(twm_pkg::twm_state_t s);
		scl_pull = (s == twm_pkg::TWM_SETUP) || (s == twm_pkg::TWM_LOW) ||
			(s == twm_pkg::TWM_HOLD) || (s == twm_pkg::TWM_STOPL);
	endfunction

	twm_sync u_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.pin_i({scl_i, sda_i}),
		.sync_o(line_s)
	);
	assign scl_s = line_s[1];
	assign sda_s = line_s[0];

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign acc = cmd_valid_i && ready_r;
	assign qtr_done = cnt_r == `TWM_QTR_CYC - 8'h01;
	assign half_done = cnt_r == `TWM_HALF_CYC - 8'h01;
	// [R12] [R13] refuse meaningless and reserved
	assign start_ok = !(cmd_addr_i == `TWM_GC_ADDR && cmd_dir_i == `TWM_DIR_READ) &&
		(cmd_addr_i[6:3] != `TWM_RSVD_TOP) && !(busy_r && state_r == twm_pkg::TWM_IDLE);
	// [R20] outside a transfer only a start is taken
	assign bad_cmd = acc && (cmd_kind_i == twm_pkg::TWM_CMD_START ? !start_ok :
		state_r == twm_pkg::TWM_IDLE);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			twm_pkg::TWM_IDLE: begin
				if (acc && !bad_cmd) begin
					state_nxt = twm_pkg::TWM_SETUP;
				end
			end
			twm_pkg::TWM_SETUP: begin
				if (qtr_done) begin
					state_nxt = twm_pkg::TWM_SCLUP;
				end
			end
			twm_pkg::TWM_SCLUP: begin
				if (scl_s && qtr_done) begin
					state_nxt = twm_pkg::TWM_START;
				end
			end
			twm_pkg::TWM_START: begin
				if (qtr_done) begin
					state_nxt = twm_pkg::TWM_LOW;
				end
			end
			twm_pkg::TWM_LOW: begin
				if (half_done) begin
					state_nxt = twm_pkg::TWM_HIGH;
				end
			end
			twm_pkg::TWM_HIGH: begin
				if (scl_s && half_done) begin
					state_nxt = (bit_cnt_r == `TWM_LAST_BIT) ? twm_pkg::TWM_HOLD : twm_pkg::TWM_LOW;
				end
			end
			twm_pkg::TWM_HOLD: begin
				if (acc && !bad_cmd) begin
					case (cmd_kind_i)
						twm_pkg::TWM_CMD_START: state_nxt = twm_pkg::TWM_SETUP;
						twm_pkg::TWM_CMD_STOP: state_nxt = twm_pkg::TWM_STOPL;
						default: state_nxt = twm_pkg::TWM_LOW;
					endcase
				end
			end
			twm_pkg::TWM_STOPL: begin
				if (qtr_done) begin
					state_nxt = twm_pkg::TWM_STOPH;
				end
			end
			twm_pkg::TWM_STOPH: begin
				if (scl_s && qtr_done) begin
					state_nxt = twm_pkg::TWM_STOPR;
				end
			end
			twm_pkg::TWM_STOPR: begin
				if (half_done) begin
					state_nxt = twm_pkg::TWM_IDLE;
				end
			end
			default: state_nxt = twm_pkg::TWM_IDLE;
		endcase
		// [R18] disabling drops the transfer; the bus may be left mid-packet
		if (!en_r) begin
			state_nxt = twm_pkg::TWM_IDLE;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_r <= twm_pkg::TWM_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// [R19] [R21] phase timer, kept at zero while the clock line is held low
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			cnt_r <= 8'h00;
		end else if (state_nxt != state_r) begin
			cnt_r <= 8'h00;
		end else if (!scl_pull(state_r) && !scl_s && state_r != twm_pkg::TWM_IDLE &&
			state_r != twm_pkg::TWM_STOPR && state_r != twm_pkg::TWM_START) begin
			cnt_r <= 8'h00;
		end else if (cnt_r != 8'hFF) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// ----------------------------------------
	// Shift paths
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			shift_r <= 9'h1FF;
			bit_cnt_r <= 4'h0;
		end else if (acc && !bad_cmd) begin
			bit_cnt_r <= 4'h0;
			case (cmd_kind_i)
				// [R6] [R7] [R10] address, direction, released acknowledge slot
				twm_pkg::TWM_CMD_START: shift_r <= {cmd_addr_i, cmd_dir_i, 1'b1};
				// [R14] [R15] write: slave drives the ninth bit
				twm_pkg::TWM_CMD_WRITE: shift_r <= {cmd_data_i, 1'b1};
				// [R16] [R17] read: we answer in the ninth bit
				twm_pkg::TWM_CMD_READ: shift_r <= {`TWM_RD_FILL, cmd_nack_i};
				default: shift_r <= 9'h1FF;
			endcase
		end else if (state_r == twm_pkg::TWM_HIGH && state_nxt != twm_pkg::TWM_HIGH) begin
			shift_r <= {shift_r[7:0], 1'b1};
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end
	end

	// Sample a quarter into the high phase, well clear of both edges
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			rx_r <= 9'h000;
		end else if (state_r == twm_pkg::TWM_HIGH && scl_s && qtr_done) begin
			rx_r <= {rx_r[7:0], sda_s};
		end
	end

	// ----------------------------------------
	// Bus activity watch
	// ----------------------------------------
	// [R3] [R4] start sets busy, stop clears it, from any master
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			sda_d_r <= 1'b1;
			busy_r <= 1'b0;
		end else begin
			sda_d_r <= sda_s;
			if (scl_s && sda_d_r && !sda_s) begin
				busy_r <= 1'b1;
			end else if (scl_s && !sda_d_r && sda_s) begin
				busy_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Line drive
	// ----------------------------------------
	// [R5] [R22] lines only pulled low or released
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			scl_oe_r <= 1'b0;
		end else begin
			scl_oe_r <= scl_pull(state_r);
		end
	end

	// [R1] [R2] data moves a quarter into clock low; start and stop edges under high clock
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
				twm_pkg::TWM_START, twm_pkg::TWM_STOPL, twm_pkg::TWM_STOPH: sda_oe_r <= 1'b1;
				twm_pkg::TWM_LOW: sda_oe_r <= (cnt_r < `TWM_QTR_CYC) ? sda_oe_r : !shift_r[8];
				twm_pkg::TWM_HIGH: sda_oe_r <= sda_oe_r;
				twm_pkg::TWM_HOLD: sda_oe_r <= (cnt_r < `TWM_QTR_CYC) ? sda_oe_r : 1'b0;
				default: sda_oe_r <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Answers and status
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			en_r <= 1'b0;
			pwr_off_r <= 1'b1;
			ready_r <= 1'b0;
		end else begin
			en_r <= enable_i;
			// [R18] unit powered only while enabled
			pwr_off_r <= !enable_i;
			ready_r <= en_r && !acc && (state_nxt == twm_pkg::TWM_IDLE || state_nxt == twm_pkg::TWM_HOLD);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			rsp_valid_r <= 1'b0;
			rsp_err_r <= 1'b0;
			rsp_nack_r <= 1'b0;
			rsp_data_r <= 8'h00;
		end else begin
			rsp_valid_r <= bad_cmd || (state_r != state_nxt &&
				(state_nxt == twm_pkg::TWM_HOLD || state_r == twm_pkg::TWM_STOPR));
			rsp_err_r <= bad_cmd;
			// [R8] [R9] [R11] [R16] ninth bit reported as seen on the line
			if (state_r == twm_pkg::TWM_HIGH && state_nxt == twm_pkg::TWM_HOLD) begin
				rsp_data_r <= rx_r[8:1];
				rsp_nack_r <= rx_r[0];
			end
		end
	end

	assign cmd_ready_o = ready_r;
	assign rsp_valid_o = rsp_valid_r;
	assign rsp_data_o = rsp_data_r;
	assign rsp_nack_o = rsp_nack_r;
	assign rsp_err_o = rsp_err_r;
	assign bus_busy_o = busy_r;
	assign serial_bus_power_off_bit_o = pwr_off_r;
	assign scl_oe_o = scl_oe_r;
	assign sda_oe_o = sda_oe_r;
	// Open drain: the drive value is always low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	sda_steady_high_a: assert property (state_r == twm_pkg::TWM_HIGH && $past(state_r) == twm_pkg::TWM_HIGH |-> // [R1]
		$stable(sda_oe_o)) else $error("data moved during clock high");
	start_edge_a: assert property (state_r == twm_pkg::TWM_START && $past(state_r) == twm_pkg::TWM_SCLUP |=> // [R2]
		!scl_oe_o && sda_oe_o) else $error("start not under high clock");
	busy_refuse_a: assert property (acc && cmd_kind_i == twm_pkg::TWM_CMD_START && busy_r && // [R3]
		state_r == twm_pkg::TWM_IDLE |=> rsp_err_o && state_r == twm_pkg::TWM_IDLE) else $error("start taken while busy");
	rep_start_a: assert property (state_r == twm_pkg::TWM_HOLD && acc && !bad_cmd && // [R4]
		cmd_kind_i == twm_pkg::TWM_CMD_START |=> state_r == twm_pkg::TWM_SETUP) else $error("repeated start lost");
	nine_bits_a: assert property (state_r == twm_pkg::TWM_HIGH && state_nxt == twm_pkg::TWM_HOLD |-> // [R6]
		bit_cnt_r == 4'h8) else $error("packet not nine bits");
	msb_first_a: assert property (state_r == twm_pkg::TWM_IDLE && acc && !bad_cmd |=> // [R10]
		shift_r[8] == $past(cmd_addr_i[6]) && shift_r[1] == $past(cmd_dir_i)) else $error("address order wrong");
	gc_read_a: assert property (acc && cmd_kind_i == twm_pkg::TWM_CMD_START && cmd_addr_i == 7'h00 && // [R12]
		cmd_dir_i |=> rsp_valid_o && rsp_err_o) else $error("general call read sent");
	rsvd_addr_a: assert property (acc && cmd_kind_i == twm_pkg::TWM_CMD_START && cmd_addr_i[6:3] == 4'hF |=> // [R13]
		rsp_err_o && state_r != twm_pkg::TWM_SETUP) else $error("reserved address sent");
	stretch_wait_a: assert property (state_r == twm_pkg::TWM_HIGH && !scl_s && $past(state_r) == twm_pkg::TWM_HIGH |-> // [R21]
		cnt_r == 8'h00) else $error("high phase timed under held clock");
	power_off_a: assert property (!enable_i |-> ##2 state_r == twm_pkg::TWM_IDLE ##1 // [R18]
		!scl_oe_o && !sda_oe_o) else $error("bus driven while powered off");

	write_done_c: cover property (state_r == twm_pkg::TWM_HOLD && rsp_valid_o && !rsp_nack_o);
	read_nack_c: cover property (state_r == twm_pkg::TWM_HOLD && rsp_valid_o && rsp_nack_o);
	rep_start_c: cover property (state_r == twm_pkg::TWM_HOLD ##1 state_r == twm_pkg::TWM_SETUP);
	stretch_c: cover property (state_r == twm_pkg::TWM_HIGH && !scl_s [*8]);
endmodule // twm_master

/* rtl/twm_cfg.svh */
// Constants for the two-wire bus master: timing counts and address fields.
// Assumes a 100 MHz system clock and a bus run at the fast-mode limit.
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TWM_CLK_NS 10
`define TWM_SCL_NS 2500
// Quarter of the bus clock period, rounded up so the rate never exceeds the limit
`define TWM_QTR_CYC 8'((`TWM_SCL_NS + 4 * `TWM_CLK_NS - 1) / (4 * `TWM_CLK_NS))
`define TWM_HALF_CYC 8'(2 * `TWM_QTR_CYC)

// ----------------------------------------
// Packet fields
// ----------------------------------------
`define TWM_LAST_BIT 4'h8
`define TWM_GC_ADDR 7'h00
`define TWM_RSVD_TOP 4'hF
`define TWM_DIR_READ 1'b1
`define TWM_RD_FILL 8'hFF

`endif

/* rtl/twm_pkg.sv */
// Types shared by the two-wire bus master files.
// Assumes nothing beyond a SystemVerilog compiler.
package twm_pkg;

	typedef enum logic [3:0] {
		TWM_IDLE = 4'h0,
		TWM_SETUP = 4'h1,
		TWM_SCLUP = 4'h3,
		TWM_START = 4'h2,
		TWM_LOW = 4'h6,
		TWM_HIGH = 4'h7,
		TWM_HOLD = 4'h5,
		TWM_STOPL = 4'h4,
		TWM_STOPH = 4'hC,
		TWM_STOPR = 4'hD
	} twm_state_t;

	typedef enum logic [1:0] {
		TWM_CMD_START = 2'h0,
		TWM_CMD_WRITE = 2'h1,
		TWM_CMD_READ = 2'h2,
		TWM_CMD_STOP = 2'h3
	} twm_cmd_t;

endpackage

/* rtl/twm_sync.sv */
// Two-flop synchroniser for the bus line levels.
// Assumes the inputs are pin levels from outside the clock domain.
module twm_sync (
	input wire logic mclk_i, // System clock
	input wire logic rst_b_i, // Synchronous reset, active low
	input wire logic [1:0] pin_i, // Raw pin levels
	output logic [1:0] sync_o // Synchronised levels
);
	logic [1:0] meta_r;
	logic [1:0] sync_r;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_line
			always_ff @(posedge mclk_i) begin
				if (!rst_b_i) begin
					meta_r[g] <= 1'b1;
					sync_r[g] <= 1'b1;
				end else begin
					meta_r[g] <= pin_i[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_r;
endmodule // twm_sync

/* dv/twm_slave_model.sv */
// Slave device model on the two-wire bus: acks its address and general call, serves reads, may stretch.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
module twm_slave_model #(
	parameter logic [6:0] OWN_ADDR = 7'h2A, // Own address; never of the 1111xxx form
	parameter logic [7:0] RD_BYTE = 8'h3C, // Byte served on every read
	parameter int STRETCH_NS = 3000 // Time the clock is held low after each fall when stretching
) (
	input wire logic scl_i, // Clock line level
	input wire logic sda_i, // Data line level
	input wire logic stretch_i, // Hold clock low after each fall
	output logic scl_oe_o, // Pull clock line low
	output logic sda_oe_o, // Pull data line low
	output logic [7:0] rx_addr_o, // Last address byte seen
	output logic [7:0] rx_byte_o // Last byte written to us
);
	timeunit 1ns;
	timeprecision 1ps;
	int bit_cnt = 0;
	logic [7:0] sh = 8'h00;
	logic addr_ph = 1'b0;
	logic sel = 1'b0;
	logic tx_on = 1'b0;
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
		rx_addr_o = 8'h00;
		rx_byte_o = 8'h00;
	end
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			bit_cnt = 0;
			addr_ph = 1'b1;
			sel = 1'b0;
			tx_on = 1'b0;
		end
	end
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			addr_ph = 1'b0;
			sel = 1'b0;
			tx_on = 1'b0;
		end
	end
	// Sample on rising clock, MSB first; a high ninth bit ends our sending
	always @(posedge scl_i) begin
		if (bit_cnt < 8)
			sh = {sh[6:0], sda_i};
		else if (tx_on && sda_i)
			tx_on = 1'b0;
		bit_cnt++;
	end
	// Ack and read bits, changed only while clock low
	always @(negedge scl_i) begin
		if (bit_cnt == 9) begin
			bit_cnt = 0;
			addr_ph = 1'b0;
		end
		sda_oe_o = 1'b0;
		if (bit_cnt == 8 && addr_ph) begin
			rx_addr_o = sh;
			sel = (sh[7:1] == OWN_ADDR) || (sh == 8'h00);
			tx_on = sel && sh[0];
			sda_oe_o = sel;
		end else if (bit_cnt == 8 && sel && !tx_on) begin
			rx_byte_o = sh;
			sda_oe_o = 1'b1;
		end else if (tx_on && bit_cnt < 8) begin
			sda_oe_o = !RD_BYTE[7 - bit_cnt];
		end
	end
	// Slow answer: hold the clock low for a while
	always @(negedge scl_i) begin
		if (stretch_i) begin
			scl_oe_o = 1'b1;
			#(STRETCH_NS);
			scl_oe_o = 1'b0;
		end
	end
endmodule // twm_slave_model

/* dv/tb_twm_master.sv */
// Bench for the two-wire bus master: drives commands, judges answers and the slave's view.
// Assumes the design files and the slave model are compiled first.
module tb_twm_master;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] SLV = 7'h2A;
	logic mclk_i = 1'b0, rst_b_i = 1'b0, enable_i = 1'b1, cmd_valid_i = 1'b0, cmd_dir_i = 1'b0;
	logic cmd_nack_i = 1'b0, stretch = 1'b0;
	// Another master's pull on the data line, to occupy the bus from outside
	logic ext_sda = 1'b0;
	logic [1:0] cmd_kind_i = 2'h0;
	logic [6:0] cmd_addr_i = 7'h00;
	logic [7:0] cmd_data_i = 8'h00;
	logic cmd_ready_o, rsp_valid_o, rsp_nack_o, rsp_err_o, bus_busy_o, serial_bus_power_off_bit_o;
	logic scl_o, scl_oe_o, sda_o, sda_oe_o, s_scl_oe, s_sda_oe, r_nack, r_err, r_busy;
	logic [7:0] rsp_data_o, rx_addr, rx_byte, r_data;
	int err_total = 0;
	int checks = 0;
	// Wired-AND with pull-ups
	wire scl = (scl_oe_o ? scl_o : 1'b1) & !s_scl_oe;
	wire sda = (sda_oe_o ? sda_o : 1'b1) & !s_sda_oe & !ext_sda;

	twm_master twm_master_i (.mclk_i, .rst_b_i, .enable_i, .cmd_valid_i, .cmd_ready_o, .cmd_kind_i,
		.cmd_addr_i, .cmd_dir_i, .cmd_data_i, .cmd_nack_i, .rsp_valid_o, .rsp_data_o, .rsp_nack_o,
		.rsp_err_o, .bus_busy_o, .serial_bus_power_off_bit_o, .scl_i(scl), .scl_o, .scl_oe_o,
		.sda_i(sda), .sda_o, .sda_oe_o);
	twm_slave_model #(.OWN_ADDR(SLV)) twm_slave_model_i (.scl_i(scl), .sda_i(sda), .stretch_i(stretch),
		.scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .rx_addr_o(rx_addr), .rx_byte_o(rx_byte));

	initial begin
		forever #5 mclk_i = ~mclk_i;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_up(input string what);
		err_total++;
		$display("Error %s expected answer seen none", what);
		report_and_stop();
	endtask

	// Waits only on the design's own handshakes, each under a bound
	task automatic issue(input twm_pkg::twm_cmd_t k, input logic [6:0] a, input logic d,
		input logic [7:0] b, input logic nk);
		int n;
		for (n = 0; n < 50 && cmd_ready_o !== 1'b1; n++) @(posedge mclk_i);
		if (n == 50) give_up("cmd_ready_o");
		cmd_kind_i <= k;
		cmd_addr_i <= a;
		cmd_dir_i <= d;
		cmd_data_i <= b;
		cmd_nack_i <= nk;
		cmd_valid_i <= 1'b1;
		@(posedge mclk_i);
		for (n = 1; n < 50 && cmd_ready_o !== 1'b1; n++) @(posedge mclk_i);
		if (n == 50) give_up("cmd take");
		cmd_valid_i <= 1'b0;
		for (n = 0; n < 9000 && rsp_valid_o !== 1'b1; n++) @(posedge mclk_i);
		if (n == 9000) give_up("rsp_valid_o");
		r_data = rsp_data_o;
		r_nack = rsp_nack_o;
		r_err = rsp_err_o;
		r_busy = bus_busy_o;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_power();
		@(posedge mclk_i);
		enable_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk("power off bit", 1, serial_bus_power_off_bit_o);
		chk("ready while off", 0, cmd_ready_o);
		enable_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		chk("power off bit", 0, serial_bus_power_off_bit_o);
		$display("test power done");
	endtask

	task automatic t_write();
		issue(twm_pkg::TWM_CMD_START, SLV, 1'b0, 8'h00, 1'b0);
		chk("address nack", 0, {r_err, r_nack});
		chk("address byte", {SLV, 1'b0}, rx_addr);
		chk("busy", 1, r_busy);
		issue(twm_pkg::TWM_CMD_WRITE, 7'h00, 1'b0, 8'hA5, 1'b0);
		chk("write nack", 0, r_nack);
		chk("write byte", 8'hA5, rx_byte);
		chk("write echo", 8'hA5, r_data);
		issue(twm_pkg::TWM_CMD_STOP, 7'h00, 1'b0, 8'h00, 1'b0);
		chk("busy after stop", 0, r_busy);
		$display("test write done");
	endtask

	task automatic t_read();
		stretch <= 1'b1;
		issue(twm_pkg::TWM_CMD_START, SLV, 1'b0, 8'h00, 1'b0);
		issue(twm_pkg::TWM_CMD_START, SLV, 1'b1, 8'h00, 1'b0);
		chk("repeated start", 0, {r_err, r_nack});
		chk("read address", {SLV, 1'b1}, rx_addr);
		chk("busy kept", 1, r_busy);
		issue(twm_pkg::TWM_CMD_READ, 7'h00, 1'b0, 8'h00, 1'b0);
		chk("read byte", 8'h3C, r_data);
		issue(twm_pkg::TWM_CMD_READ, 7'h00, 1'b0, 8'h00, 1'b1);
		chk("last read", {8'h3C}, r_data);
		chk("our nack", 1, r_nack);
		issue(twm_pkg::TWM_CMD_STOP, 7'h00, 1'b0, 8'h00, 1'b0);
		chk("lines released", 8'h03, {scl, sda});
		stretch <= 1'b0;
		$display("test read done");
	endtask

	task automatic t_refuse();
		issue(twm_pkg::TWM_CMD_WRITE, 7'h00, 1'b0, 8'h11, 1'b0);
		chk("write when idle", 1, r_err);
		issue(twm_pkg::TWM_CMD_STOP, 7'h00, 1'b0, 8'h00, 1'b0);
		chk("empty stop", 1, r_err);
		issue(twm_pkg::TWM_CMD_START, 7'h00, 1'b1, 8'h00, 1'b0);
		chk("general call read", 1, r_err);
		issue(twm_pkg::TWM_CMD_START, 7'h78, 1'b0, 8'h00, 1'b0);
		chk("reserved address", 1, r_err);
		chk("bus untouched", 8'h03, {scl, sda});
		chk("drive values", 0, {scl_o, sda_o});
		$display("test refuse done");
	endtask

	task automatic t_gc();
		issue(twm_pkg::TWM_CMD_START, 7'h11, 1'b0, 8'h00, 1'b0);
		chk("absent slave", 1, r_nack);
		issue(twm_pkg::TWM_CMD_START, 7'h00, 1'b0, 8'h00, 1'b0);
		chk("general call ack", 0, {r_err, r_nack});
		issue(twm_pkg::TWM_CMD_START, 7'h7F, 1'b0, 8'h00, 1'b0);
		chk("reserved in transfer", 1, r_err);
		issue(twm_pkg::TWM_CMD_WRITE, 7'h00, 1'b0, 8'h5A, 1'b0);
		chk("general call data", 8'h5A, rx_byte);
		chk("data ack", 0, r_nack);
		issue(twm_pkg::TWM_CMD_STOP, 7'h00, 1'b0, 8'h00, 1'b0);
		chk("stop ok", 0, r_err);
		$display("test general call done");
	endtask

	task automatic t_busy();
		ext_sda <= 1'b1;
		repeat (5) @(posedge mclk_i);
		chk("busy by other", 1, bus_busy_o);
		issue(twm_pkg::TWM_CMD_START, SLV, 1'b0, 8'h00, 1'b0);
		chk("start while busy", 1, r_err);
		ext_sda <= 1'b0;
		repeat (5) @(posedge mclk_i);
		chk("free after stop", 0, bus_busy_o);
		$display("test busy done");
	endtask

	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		t_power();
		t_write();
		t_read();
		t_refuse();
		t_gc();
		t_busy();
		report_and_stop();
	end
endmodule // tb_twm_master
